// >>> pkg/low_power_mode_control_params.svh
// constants of the low-power mode controller: offsets, fields, counts
// assumes a 32-bit apb register bus and a 40 mhz core clock
`ifndef LOW_POWER_MODE_CONTROL_PARAMS_SVH
`define LOW_POWER_MODE_CONTROL_PARAMS_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define LPM_OFF_MODE       8'h00
`define LPM_OFF_TIMER_CTRL 8'h04
`define LPM_OFF_CCR        8'h08
`define LPM_OFF_WDOG       8'h0c
`define LPM_OFF_STATUS     8'h10
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LPM_BIT_STOP       0
`define LPM_BIT_WAIT       1
`define LPM_BIT_CAP_IE     0
`define LPM_BIT_CMP_IE     1
`define LPM_BIT_OVF_IE     2
`define LPM_BIT_IMASK      0
`define LPM_BIT_WDOG_CLR   0
// ----------------------------------------------------------------
// vectors, reset values and counts
// ----------------------------------------------------------------
`define LPM_VEC_EXT        16'h1ffa
`define LPM_VEC_TIMER      16'h1ff8
`define LPM_VEC_RESET      16'h1ffe
`define LPM_RST_TIMER_IE   3'h0
`define LPM_RST_IMASK      1'b1
`define LPM_PRESC_W        2
`define LPM_WDOG_W         18
`define LPM_WDOG_CYCLES    262144
`endif

// >>> pkg/low_power_mode_control_pkg.sv
// types of the low-power mode controller
// assumes the params header is on the include path
package low_power_mode_control_pkg;
  // ----------------------------------------------------------------
  // power modes, gray coded run -> wait -> stop
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_RUN  = 2'h0,
    MODE_WAIT = 2'h1,
    MODE_STOP = 2'h3
  } lpm_mode_t;
  // ----------------------------------------------------------------
  // power control outputs toward the core
  // ----------------------------------------------------------------
  typedef struct packed {
    logic oscEnable;
    logic cpuHalt;
    logic timerTick;
  } power_ctl_t;
  // ----------------------------------------------------------------
  // vector fetch request toward the core
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        fetch;
    logic [15:0] addr;
  } vector_req_t;
endpackage

// >>> rtl/low_power_mode_control.sv
// low-power mode controller: stop and wait latches, wake, watchdog
// assumes an apb master on core_clk, async active-low reset on rst_b
//
// Behaviour
// - Stop turns the oscillator off and freezes the timer prescaler and the watchdog.
// - Stop entry clears the capture, compare and overflow interrupt enables.
// - Stop entry clears the timer prescaler.
// - Stop entry clears the interrupt mask so external interrupts can wake.
// - Apart from those bits every register keeps its value in stop.
// - Only an external interrupt or a reset ends stop; timer requests do not.
// - An external interrupt wake fetches the vector at 1ffa and 1ffb.
// - A reset fetches the vector at 1ffe and 1fff.
// - Wait halts the cpu while oscillator and timer keep running.
// - An enabled timer interrupt request ends wait.
// - The watchdog keeps counting in wait and can still force a reset.
// - Wait entry clears the interrupt mask.
// - Wait keeps all other state, the timer enables included.
// - Any reset clears the stop latch and restarts the clocks.
// - Any reset clears the wait latch and wakes the cpu.
`timescale 1ns/1ps
`include "low_power_mode_control_params.svh"

module low_power_mode_control #(
  parameter int WDOG_CYCLES = `LPM_WDOG_CYCLES
) (
  input  wire logic                                core_clk,
  input  wire logic                                rst_b,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [7:0]                          paddr,
  input  wire logic [31:0]                         pwdata,
  output      logic [31:0]                         prdata,
  output      logic                                pready,
  output      logic                                pslverr,
  input  wire logic                                extIrq_b,
  input  wire logic [2:0]                          timerFlags,
  output      low_power_mode_control_pkg::power_ctl_t  powerCtl,
  output      low_power_mode_control_pkg::vector_req_t vectorReq,
  output      logic                                watchdogReset
);
  import low_power_mode_control_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  lpm_mode_t                 mode;
  lpm_mode_t                 next_mode;
  logic [2:0]                timerIntEn;
  logic                      irqMask;
  logic [`LPM_PRESC_W-1:0]   presc;
  logic [`LPM_WDOG_W-1:0]    wdogCount;
  logic                      irqMeta;
  logic                      irqSync;
  logic                      resetVecPending;
  logic                      wdogTimeout;
  logic                      extReq;
  logic                      timerReq;
  logic                      apbWrite;
  logic                      apbSetup;
  logic                      cmdStop;
  logic                      cmdWait;
  logic                      wdogClear;
  logic                      maskWrite;
  logic                      tctlWrite;
  logic                      wakeExt;
  logic                      wakeTimer;
  logic                      enterStop;
  logic                      enterWait;
  logic [31:0]               readValue;
  logic                      readHit;

  localparam logic [`LPM_WDOG_W-1:0] WDOG_LAST =
    `LPM_WDOG_W'(WDOG_CYCLES - 1);

  // ----------------------------------------------------------------
  // external interrupt pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irqMeta <= 1'b1;
      irqSync <= 1'b1;
    end else begin
      irqMeta <= extIrq_b;
      irqSync <= irqMeta;
    end
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign apbSetup  = psel & ~penable;
  assign apbWrite  = psel & penable & pready & pwrite & ~pslverr;
  assign cmdStop   = apbWrite & (paddr == `LPM_OFF_MODE) &
                     pwdata[`LPM_BIT_STOP];
  assign cmdWait   = apbWrite & (paddr == `LPM_OFF_MODE) &
                     pwdata[`LPM_BIT_WAIT] & ~pwdata[`LPM_BIT_STOP];
  assign wdogClear = apbWrite & (paddr == `LPM_OFF_WDOG) &
                     ~pwdata[`LPM_BIT_WDOG_CLR];
  assign maskWrite = apbWrite & (paddr == `LPM_OFF_CCR);
  assign tctlWrite = apbWrite & (paddr == `LPM_OFF_TIMER_CTRL);

  always_comb begin
    readValue = 32'h0;
    readHit   = 1'b1;
    unique case (paddr)
      `LPM_OFF_MODE:       readValue = {30'h0, mode};
      `LPM_OFF_TIMER_CTRL: readValue = {29'h0, timerIntEn};
      `LPM_OFF_CCR:        readValue = {31'h0, irqMask};
      `LPM_OFF_WDOG:       readValue = {14'h0, wdogCount};
      `LPM_OFF_STATUS:     readValue = {28'h0, presc, powerCtl.cpuHalt,
                                        powerCtl.oscEnable};
      default:             readHit   = 1'b0;
    endcase
  end

  // no wait state: answer is prepared in the setup cycle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= apbSetup;
      pslverr <= apbSetup & ~readHit;
      prdata  <= (apbSetup & ~pwrite & readHit) ? readValue : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // wake qualification
  // ----------------------------------------------------------------
  assign extReq    = ~irqSync & ~irqMask;
  assign timerReq  = |(timerFlags & timerIntEn) & ~irqMask;
  assign wdogTimeout = (mode != MODE_STOP) & (wdogCount == WDOG_LAST) &
                       ~wdogClear;
  assign enterStop = (mode == MODE_RUN) & cmdStop & ~wdogTimeout;
  assign enterWait = (mode == MODE_RUN) & cmdWait & ~wdogTimeout;
  // only the pin wakes from stop; timer requests count only in wait
  assign wakeExt   = (mode != MODE_RUN) & extReq & ~wdogTimeout;
  assign wakeTimer = (mode == MODE_WAIT) & timerReq & ~extReq &
                     ~wdogTimeout;

  // ----------------------------------------------------------------
  // mode latch
  // ----------------------------------------------------------------
  always_comb begin
    next_mode = mode;
    unique case (mode)
      MODE_RUN: begin
        if (enterStop) begin
          next_mode = MODE_STOP;
        end else if (enterWait) begin
          next_mode = MODE_WAIT;
        end
      end
      MODE_WAIT: begin
        if (wakeExt | wakeTimer) begin
          next_mode = MODE_RUN;
        end
      end
      MODE_STOP: begin
        if (wakeExt) begin
          next_mode = MODE_RUN;
        end
      end
      default: next_mode = MODE_RUN;
    endcase
    if (wdogTimeout) begin
      next_mode = MODE_RUN;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode <= MODE_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  // ----------------------------------------------------------------
  // interrupt mask: wake vectoring sets it, mode entry clears it
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irqMask <= `LPM_RST_IMASK;
    end else if (wdogTimeout | wakeExt | wakeTimer) begin
      irqMask <= 1'b1;
    end else if (enterStop | enterWait) begin
      irqMask <= 1'b0;
    end else if (maskWrite & (mode == MODE_RUN)) begin
      irqMask <= pwdata[`LPM_BIT_IMASK];
    end
  end

  // ----------------------------------------------------------------
  // timer interrupt enables
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      timerIntEn <= `LPM_RST_TIMER_IE;
    end else if (wdogTimeout | enterStop) begin
      timerIntEn <= 3'h0;
    end else if (tctlWrite & (mode == MODE_RUN)) begin
      // held through wait and stop otherwise
      timerIntEn <= pwdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // timer prescaler, frozen in stop
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      presc <= '0;
    end else if (wdogTimeout | enterStop) begin
      presc <= '0;
    end else if (mode != MODE_STOP) begin
      presc <= presc + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // watchdog, counting in run and wait
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wdogCount <= '0;
    end else if (wdogClear | wdogTimeout) begin
      wdogCount <= '0;
    end else if (mode != MODE_STOP) begin
      wdogCount <= wdogCount + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // outputs toward the core
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      powerCtl      <= '{oscEnable: 1'b1, cpuHalt: 1'b0, timerTick: 1'b0};
      watchdogReset <= 1'b0;
    end else begin
      powerCtl.oscEnable <= (next_mode != MODE_STOP);
      powerCtl.cpuHalt   <= (next_mode != MODE_RUN);
      powerCtl.timerTick <= (mode != MODE_STOP) & ~enterStop &
                            (&presc);
      watchdogReset      <= wdogTimeout;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      resetVecPending <= 1'b1;
      vectorReq       <= '{fetch: 1'b0, addr: 16'h0};
    end else begin
      resetVecPending <= 1'b0;
      vectorReq.fetch <= resetVecPending | wdogTimeout | wakeExt |
                         wakeTimer;
      if (resetVecPending | wdogTimeout) begin
        vectorReq.addr <= `LPM_VEC_RESET;
      end else if (wakeExt) begin
        vectorReq.addr <= `LPM_VEC_EXT;
      end else if (wakeTimer) begin
        vectorReq.addr <= `LPM_VEC_TIMER;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_stop_osc_off: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    enterStop |=> !powerCtl.oscEnable && mode == MODE_STOP)
    else $error("oscillator still on after stop entry");

  chk_stop_clears_ie: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    enterStop |=> timerIntEn == 3'h0)
    else $error("timer enables not cleared on stop");

  chk_stop_presc_frozen: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    enterStop |=> presc == '0 ##1 (presc == '0 || mode != MODE_STOP))
    else $error("prescaler not cleared or not frozen in stop");

  chk_entry_clears_mask: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (enterStop || enterWait) |=> !irqMask)
    else $error("interrupt mask not cleared on low-power entry");

  chk_stop_wake_src: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (mode == MODE_STOP && irqSync) |=> mode == MODE_STOP)
    else $error("stop left without external interrupt or reset");

  chk_ext_vector: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    wakeExt |=> vectorReq.fetch && vectorReq.addr == 16'h1ffa)
    else $error("wrong vector after external wake");

  chk_wdog_vector: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    wdogTimeout |=> watchdogReset && vectorReq.addr == 16'h1ffe &&
    mode == MODE_RUN && powerCtl.oscEnable)
    else $error("watchdog reset did not restart at reset vector");

  chk_wait_runs: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (mode == MODE_WAIT && !wdogClear && !wdogTimeout) |=>
    powerCtl.oscEnable && wdogCount == $past(wdogCount) + 1'b1)
    else $error("clock or watchdog stopped in wait");

  chk_wait_timer_wake: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    wakeTimer |=> mode == MODE_RUN && !powerCtl.cpuHalt && irqMask)
    else $error("timer request did not end wait");

  chk_wait_keeps_ie: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (mode == MODE_WAIT && !wdogTimeout) |=> $stable(timerIntEn))
    else $error("timer enables changed in wait");

  chk_stop_clocks_off: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (mode == MODE_STOP) |-> !powerCtl.oscEnable && powerCtl.cpuHalt)
    else $error("clocks still running in stop");

  chk_stop_wdog_frozen: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (mode == MODE_STOP && !wdogClear) |=> $stable(wdogCount))
    else $error("watchdog counted in stop");

  chk_stop_keeps_ie: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (mode == MODE_STOP) |=> $stable(timerIntEn))
    else $error("timer enables changed in stop");

  chk_reset_vector: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    resetVecPending |=> vectorReq.fetch && vectorReq.addr == 16'h1ffe)
    else $error("reset did not fetch the reset vector");
endmodule

// >>> verification/lpm_far_side.sv
// far side model: external interrupt pin and reset sources
// assumes it shares the core clock of the low-power controller
`timescale 1ns/1ps

module lpm_far_side (
  input  wire logic core_clk,
  output      logic rst_b,
  output      logic extIrq_b
);
  // ----------------------------------------------------------------
  // pins start in reset with the interrupt line idle high
  // ----------------------------------------------------------------
  initial begin
    rst_b    = 1'b0;
    extIrq_b = 1'b1;
  end

  // reset pulse, low for n edges
  task automatic resetFor(input int n);
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (n) @(posedge core_clk);
    rst_b <= 1'b1;
  endtask

  // level interrupt line, active low
  task automatic setIrq(input logic level);
    @(posedge core_clk);
    extIrq_b <= level;
  endtask
endmodule

// >>> verification/testbench.sv
// self-checking bench of the low-power mode controller over apb
// assumes the params header on the include path, far side model
`timescale 1ns/1ps
`include "low_power_mode_control_params.svh"

module testbench;
  import low_power_mode_control_pkg::*;
  localparam int WDOG = 256;
  logic        core_clk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        extIrq_b;
  logic [2:0]  timerFlags;
  power_ctl_t  powerCtl;
  vector_req_t vectorReq;
  logic        watchdogReset;
  int          errTotal = 0;
  int          compares = 0;
  int          wdogSeen = 0;
  logic [31:0] rd;
  logic [31:0] w0;
  logic        err;
  int          c;

  low_power_mode_control #(.WDOG_CYCLES(WDOG)) i_low_power_mode_control (
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .extIrq_b(extIrq_b),
    .timerFlags(timerFlags), .powerCtl(powerCtl), .vectorReq(vectorReq),
    .watchdogReset(watchdogReset)
  );

  lpm_far_side i_lpm_far_side (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .extIrq_b(extIrq_b)
  );

  // ----------------------------------------------------------------
  // clock, watchdog pulse monitor, timeout
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (watchdogReset === 1'b1) wdogSeen <= wdogSeen + 1;
  end

  initial begin
    #500000;
    errTotal++;
    summarize();
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      errTotal++;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk("pready", 32'h1, {31'h0, pready});
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] e, m);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg%0h", a), e, rd & m);
  endtask

  task automatic waitFetch(input logic [15:0] e);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (vectorReq.fetch !== 1'b1 && n < 60);
    chk("fetch", 32'h1, {31'h0, vectorReq.fetch});
    chk("vector", {16'h0, e}, {16'h0, vectorReq.addr});
  endtask

  task automatic countTicks(input int n);
    c = 0;
    repeat (n) begin
      @(posedge core_clk);
      if (powerCtl.timerTick === 1'b1) c++;
    end
  endtask

  task automatic setFlags(input logic [2:0] f);
    timerFlags <= f;
  endtask

  task automatic summarize();
    if (errTotal == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h0;
    setFlags(3'h0);
    i_lpm_far_side.resetFor(4);
    waitFetch(`LPM_VEC_RESET);
    rdChk(`LPM_OFF_MODE, 32'h0, 32'h3);
    rdChk(`LPM_OFF_STATUS, 32'h1, 32'h3);
    // stop entry, frozen state, only external wake
    apb(1'b1, `LPM_OFF_WDOG, 32'h0);
    apb(1'b1, `LPM_OFF_TIMER_CTRL, 32'h7);
    apb(1'b1, `LPM_OFF_MODE, 32'h1);
    rdChk(`LPM_OFF_MODE, 32'h3, 32'h3);
    rdChk(`LPM_OFF_TIMER_CTRL, 32'h0, 32'h7);
    rdChk(`LPM_OFF_CCR, 32'h0, 32'h1);
    rdChk(`LPM_OFF_STATUS, 32'h2, 32'hf);
    apb(1'b0, `LPM_OFF_WDOG, 32'h0);
    w0 = rd;
    countTicks(8);
    chk("stopTicks", 32'h0, c);
    rdChk(`LPM_OFF_WDOG, w0, 32'h3ffff);
    setFlags(3'h7);
    repeat (12) @(posedge core_clk);
    rdChk(`LPM_OFF_MODE, 32'h3, 32'h3);
    i_lpm_far_side.setIrq(1'b0);
    waitFetch(`LPM_VEC_EXT);
    i_lpm_far_side.setIrq(1'b1);
    setFlags(3'h0);
    rdChk(`LPM_OFF_STATUS, 32'h1, 32'h3);
    // wait entry, running timer, enabled timer wake
    apb(1'b1, `LPM_OFF_WDOG, 32'h0);
    apb(1'b1, `LPM_OFF_TIMER_CTRL, 32'h1);
    apb(1'b1, `LPM_OFF_MODE, 32'h2);
    rdChk(`LPM_OFF_MODE, 32'h1, 32'h3);
    rdChk(`LPM_OFF_CCR, 32'h0, 32'h1);
    rdChk(`LPM_OFF_TIMER_CTRL, 32'h1, 32'h7);
    rdChk(`LPM_OFF_STATUS, 32'h3, 32'h3);
    countTicks(8);
    chk("waitTicks", 32'h2, c);
    setFlags(3'h2);
    repeat (6) @(posedge core_clk);
    rdChk(`LPM_OFF_MODE, 32'h1, 32'h3);
    setFlags(3'h1);
    waitFetch(`LPM_VEC_TIMER);
    setFlags(3'h0);
    // wait by interrupt, wait by reset, stop by reset
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, `LPM_OFF_WDOG, 32'h0);
      apb(1'b1, `LPM_OFF_MODE, (k == 2) ? 32'h1 : 32'h2);
      if (k == 0) begin
        i_lpm_far_side.setIrq(1'b0);
        waitFetch(`LPM_VEC_EXT);
        i_lpm_far_side.setIrq(1'b1);
      end else begin
        i_lpm_far_side.resetFor(2);
        waitFetch(`LPM_VEC_RESET);
      end
      rdChk(`LPM_OFF_MODE, 32'h0, 32'h3);
    end
    apb(1'b0, 8'h14, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
    chk("rdata", 32'h0, rd);
    apb(1'b1, `LPM_OFF_CCR, 32'h0);
    rdChk(`LPM_OFF_CCR, 32'h0, 32'h1);
    // serviced watchdog never fires
    repeat (4) begin
      apb(1'b1, `LPM_OFF_WDOG, 32'h0);
      repeat (150) @(posedge core_clk);
    end
    chk("wdogSeen", 32'h0, wdogSeen);
    // unserviced watchdog fires in wait
    apb(1'b1, `LPM_OFF_WDOG, 32'h0);
    apb(1'b1, `LPM_OFF_MODE, 32'h2);
    c = 0;
    while (watchdogReset !== 1'b1 && c < 400) begin
      @(posedge core_clk);
      c++;
    end
    chk("wdogSpan", 32'h1, {31'h0, c > 235 && c < WDOG});
    chk("fetch", 32'h1, {31'h0, vectorReq.fetch});
    chk("vector", {16'h0, `LPM_VEC_RESET}, {16'h0, vectorReq.addr});
    rdChk(`LPM_OFF_MODE, 32'h0, 32'h3);
    rdChk(`LPM_OFF_CCR, 32'h1, 32'h1);
    summarize();
  end
endmodule
